// >>> adc_ctrl_pkg.sv
// Constants, types and helper functions for the converter sequencing block
package adc_ctrl_pkg;
    localparam logic [7:0] OFS_CTRL_ONE = 8'h00;
    localparam logic [7:0] OFS_CTRL_TWO = 8'h04;
    localparam logic [7:0] OFS_CTRL_THREE = 8'h08;
    localparam logic [7:0] OFS_SCAN_LOW = 8'h0c;
    localparam logic [7:0] OFS_SCAN_HIGH = 8'h10;
    localparam logic [7:0] OFS_PIN_CFG_LOW = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_BUF_CFG = 8'h1c;
    localparam logic [1:0] RESULT_PAGE = 2'h1;
    localparam logic [15:0] CTRL_ONE_MASK = 16'hb7ef;
    localparam logic [15:0] CTRL_TWO_MASK = 16'he73f;
    localparam logic [15:0] CTRL_THREE_MASK = 16'h9fff;
    localparam logic [15:0] REG_RST = 16'h0000;
    localparam logic [15:0] BUF_CFG_RST = 16'h1000;
    localparam int B_ON = 15;
    localparam int B_BUILD_ORDER = 12;
    localparam int B_MODE = 10;
    localparam int B_FORM = 8;
    localparam int B_TRIG = 5;
    localparam int B_AUTO = 2;
    localparam int B_ACQUIRE_ENABLE_BIT = 1;
    localparam int B_DONE = 0;
    localparam int B_REF = 13;
    localparam int B_SCAN = 10;
    localparam int B_CHPS = 8;
    localparam int B_RATE = 2;
    localparam int B_SAMC = 8;
    localparam int B_DMA_ATT = 0;
    localparam int B_CH0_SEL = 4;
    localparam int B_BUF_SIZE = 8;
    localparam int NUM_INPUTS = 9;
    localparam int RESULT_DEPTH = 16;
    localparam logic [2:0] TRIG_SOFT = 3'h0;
    localparam logic [2:0] TRIG_RESERVED = 3'h6;
    localparam logic [2:0] TRIG_AUTO = 3'h7;

    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} seqState_t;

    typedef struct packed {
        logic start;
        logic res12;
        logic [1:0] slot;
        logic [3:0] chan;
    } convReq_t;

    function automatic logic [1:0] lastSlot(input logic res12, input logic [1:0] chps);
        if (res12 || chps == 2'h0) begin
            return 2'h0;
        end else if (chps == 2'h1) begin
            return 2'h1;
        end
        return 2'h3;
    endfunction : lastSlot

    function automatic logic [3:0] nextScan(input logic [8:0] list, input logic [3:0] from);
        logic [3:0] r;
        r = 4'h0;
        for (int i = NUM_INPUTS - 1; i >= 0; i--) begin
            if (list[i]) r = 4'(i);
        end
        for (int i = NUM_INPUTS - 1; i >= 0; i--) begin
            if (list[i] && 4'(i) >= from) r = 4'(i);
        end
        return r;
    endfunction : nextScan

    function automatic logic [15:0] formatResult(input logic [11:0] d, input logic res12, input logic [1:0] form);
        logic [15:0] r;
        r = 16'h0000;
        if (res12) begin
            case (form)
                2'h0: r = {4'h0, d};
                2'h1: r = {{5{~d[11]}}, d[10:0]};
                2'h2: r = {d, 4'h0};
                default: r = {~d[11], d[10:0], 4'h0};
            endcase
        end else begin
            case (form)
                2'h0: r = {6'h00, d[9:0]};
                2'h1: r = {{7{~d[9]}}, d[8:0]};
                2'h2: r = {d[9:0], 6'h00};
                default: r = {~d[9], d[8:0], 6'h00};
            endcase
        end
        return r;
    endfunction : formatResult
endpackage : adc_ctrl_pkg

// >>> adc_result_mem.sv
// Sixteen-word result store with registered read data
`timescale 1ns/100ps
module adc_result_mem
    import adc_ctrl_pkg::*;
(
    input wire logic core_clk,
    input wire logic wrEn,
    input wire logic [3:0] wrAddr,
    input wire logic [15:0] wrData,
    input wire logic [3:0] rdAddr,
    output logic [15:0] rdData
);
    logic [15:0] store [RESULT_DEPTH];

    always_ff @(posedge core_clk) begin
        if (wrEn) store[wrAddr] <= wrData;
    end

    always_ff @(posedge core_clk) begin
        rdData <= store[rdAddr];
    end
endmodule : adc_result_mem

// >>> adc_op_counter.sv
// Sample/convert operation counter with rate wrap
`timescale 1ns/100ps
module adc_op_counter
    import adc_ctrl_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic enable,
    input wire logic opDone,
    input wire logic [3:0] rate,
    output logic [3:0] count,
    output logic wrap
);
    assign wrap = opDone && count >= rate;

    always_ff @(posedge core_clk) begin
        if (!rstn || !enable) begin
            count <= 4'h0;
        end else if (wrap) begin
            count <= 4'h0;
        end else if (opDone) begin
            count <= count + 4'h1;
        end
    end
endmodule : adc_op_counter

// >>> adc_seq_ctrl.sv
// Converter sequencing, result buffering and DMA addressing with APB registers
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/100ps
// Notes on behaviour
// - Mode bit picks 10-bit four-channel (reset default) or 12-bit one-channel
// - 10-bit mode samples up to four inputs at the same instant
// - 12-bit mode uses one sample-and-hold, converting one channel at a time
// - Nine analog inputs, numbered zero to eight, are selectable
// - A DMA request accompanies every interrupt flag set when DMA attached
// - Increment-rate field sets operations between DMA pointer increments
// - Build-order bit set gives DMA addresses in conversion order
// - Build-order bit clear gives scatter/gather address from input and size
// - Increment-rate field sets operations between interrupt flag sets
// - With scanning on, the rate count restarts the scan list
// - Without DMA, sixteen results fill in turn, pointer wraps at rate
// - With DMA, one result register is overwritten by each conversion
// - Done flag clears at conversion start, sets at completion, then holds
// - Digital input reads one only when both converters configure it digital
// - Trigger field: 000 software, 111 auto counter, 110 reserved, others events
// - Auto-start restarts sampling after the last conversion and sets sample bit
// - Increment-rate field value plus one gives the operation count
module adc_seq_ctrl
    import adc_ctrl_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic convDone,
    input wire logic [11:0] convData,
    input wire logic [7:0] trigEvent,
    input wire logic [8:0] padIn,
    input wire logic [8:0] otherPinCfg,
    output convReq_t convReq,
    output logic [3:0] sampleHold,
    output logic convClk,
    output logic [2:0] refSel,
    output logic dmaReq,
    output logic [11:0] dmaAddr,
    output logic [15:0] dmaData,
    output logic intFlag,
    output logic [8:0] digitalIn
);
    logic [15:0] ctrlOne, ctrlTwo, ctrlThree, scanLow, scanHigh, pinCfg, bufCfg;
    logic [15:0] next_ctrlOne, memRd, result;
    logic [31:0] readMux;
    logic readHit, access, wr, endSample, hwStart, convAccept, opDone, opWrap;
    seqState_t state;
    logic [1:0] slot, last;
    logic [4:0] sampCnt;
    logic [3:0] opCount, wrPtr, scanPos, curChan, firstScan;
    logic [7:0] dmaPtr, divCnt;

    assign access = psel && penable;
    assign wr = access && pready && pwrite;
    assign last = lastSlot(ctrlOne[B_MODE], ctrlTwo[B_CHPS +: 2]);
    assign convAccept = state == ST_CONVERT && convDone;
    assign opDone = convAccept && convReq.slot == last;
    assign result = formatResult(convData, ctrlOne[B_MODE], ctrlOne[B_FORM +: 2]);
    assign firstScan = nextScan(scanLow[8:0], 4'h0);

    // Register read decode
    always_comb begin
        readMux = 32'h0;
        readHit = 1'b1;
        if (paddr == OFS_CTRL_ONE) begin
            readMux[15:0] = ctrlOne;
        end else if (paddr == OFS_CTRL_TWO) begin
            readMux[15:0] = ctrlTwo;
        end else if (paddr == OFS_CTRL_THREE) begin
            readMux[15:0] = ctrlThree;
        end else if (paddr == OFS_SCAN_LOW) begin
            readMux[15:0] = scanLow;
        end else if (paddr == OFS_SCAN_HIGH) begin
            readMux[15:0] = scanHigh;
        end else if (paddr == OFS_PIN_CFG_LOW) begin
            readMux[15:0] = pinCfg;
        end else if (paddr == OFS_STATUS) begin
            readMux[31:0] = {dmaPtr, wrPtr, opCount, scanPos, 2'(state), slot, 7'h00, intFlag};
        end else if (paddr == OFS_BUF_CFG) begin
            readMux[15:0] = bufCfg;
        end else if (paddr[7:6] == RESULT_PAGE) begin
            readMux[15:0] = memRd;
        end else begin
            readHit = 1'b0;
        end
    end

    // One wait state, then answer
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else if (access && !pready) begin
            pready <= 1'b1;
            pslverr <= !readHit;
            prdata <= pwrite ? 32'h0 : readMux;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Control one with hardware-owned sample and done bits
    always_comb begin
        next_ctrlOne = ctrlOne;
        if (wr && paddr == OFS_CTRL_ONE) begin
            next_ctrlOne = pwdata[15:0] & CTRL_ONE_MASK;
            if (ctrlOne[B_ON]) next_ctrlOne[B_MODE] = ctrlOne[B_MODE];
            next_ctrlOne[B_DONE] = ctrlOne[B_DONE] & pwdata[B_DONE];
        end
        if (hwStart && ctrlOne[B_TRIG +: 3] != TRIG_SOFT) next_ctrlOne[B_ACQUIRE_ENABLE_BIT] = 1'b0;
        if (hwStart) next_ctrlOne[B_DONE] = 1'b0;
        if (convAccept) next_ctrlOne[B_DONE] = 1'b1;
        if (opDone && ctrlOne[B_AUTO]) next_ctrlOne[B_ACQUIRE_ENABLE_BIT] = 1'b1;
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            ctrlOne <= REG_RST;
        end else begin
            ctrlOne <= next_ctrlOne;
        end
    end

    // Other software registers
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            ctrlTwo <= REG_RST;
            ctrlThree <= REG_RST;
            scanLow <= REG_RST;
            scanHigh <= REG_RST;
            pinCfg <= REG_RST;
            bufCfg <= BUF_CFG_RST;
        end else if (wr) begin
            if (paddr == OFS_CTRL_TWO) ctrlTwo <= pwdata[15:0] & CTRL_TWO_MASK;
            if (paddr == OFS_CTRL_THREE) ctrlThree <= pwdata[15:0] & CTRL_THREE_MASK;
            if (paddr == OFS_SCAN_LOW) scanLow <= pwdata[15:0];
            if (paddr == OFS_SCAN_HIGH) scanHigh <= pwdata[15:0];
            if (paddr == OFS_PIN_CFG_LOW) pinCfg <= pwdata[15:0];
            if (paddr == OFS_BUF_CFG) bufCfg <= pwdata[15:0];
        end
    end

    // end of sampling by trigger source
    always_comb begin
        case (ctrlOne[B_TRIG +: 3])
            TRIG_SOFT: endSample = !ctrlOne[B_ACQUIRE_ENABLE_BIT];
            TRIG_AUTO: endSample = sampCnt >= ctrlThree[B_SAMC +: 5];
            TRIG_RESERVED: endSample = 1'b0;
            default: endSample = trigEvent[ctrlOne[B_TRIG +: 3]];
        endcase
        hwStart = state == ST_SAMPLE && endSample;
    end

    // slot zero input from scan or select
    assign curChan = ctrlTwo[B_SCAN] ? scanPos : bufCfg[B_CH0_SEL +: 4];

    // Sequencer
    always_ff @(posedge core_clk) begin
        if (!rstn || !ctrlOne[B_ON]) begin
            state <= ST_IDLE;
            slot <= 2'h0;
            sampCnt <= 5'h0;
            convReq <= '0;
        end else begin
            convReq.start <= 1'b0;
            case (state)
                ST_IDLE: begin
                    sampCnt <= 5'h0;
                    if (ctrlOne[B_ACQUIRE_ENABLE_BIT]) state <= ST_SAMPLE;
                end
                ST_SAMPLE: begin
                    sampCnt <= sampCnt + 5'h1;
                    if (endSample) begin
                        state <= ST_CONVERT;
                        slot <= 2'h0;
                        convReq <= '{start: 1'b1, res12: ctrlOne[B_MODE], slot: 2'h0, chan: curChan};
                    end
                end
                default: begin
                    if (convDone && slot != last) begin
                        slot <= slot + 2'h1;
                        convReq <= '{start: 1'b1, res12: ctrlOne[B_MODE], slot: slot + 2'h1,
                                     chan: {2'h0, slot + 2'h1}};
                    end else if (convDone) begin
                        state <= ctrlOne[B_AUTO] ? ST_SAMPLE : ST_IDLE;
                        sampCnt <= 5'h0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn || state != ST_SAMPLE) begin
            sampleHold <= 4'h0;
        end else begin
            sampleHold <= {last == 2'h3, last == 2'h3, last != 2'h0, 1'b1};
        end
    end

    adc_op_counter opCounter (
        .core_clk(core_clk),
        .rstn(rstn),
        .enable(ctrlOne[B_ON]),
        .opDone(opDone),
        .rate(ctrlTwo[B_RATE +: 4]),
        .count(opCount),
        .wrap(opWrap)
    );

    // sequential fill, single slot with DMA
    adc_result_mem resultMem (
        .core_clk(core_clk),
        .wrEn(convAccept),
        .wrAddr(bufCfg[B_DMA_ATT] ? 4'h0 : wrPtr),
        .wrData(result),
        .rdAddr(paddr[5:2]),
        .rdData(memRd)
    );

    always_ff @(posedge core_clk) begin
        if (!rstn || !ctrlOne[B_ON]) begin
            wrPtr <= 4'h0;
        end else if (convAccept) begin
            wrPtr <= opWrap ? 4'h0 : wrPtr + 4'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn || !ctrlOne[B_ON] || !ctrlTwo[B_SCAN]) begin
            scanPos <= firstScan;
        end else if (opDone) begin
            scanPos <= opWrap ? firstScan : nextScan(scanLow[8:0], scanPos + 4'h1);
        end
    end

    // flag set at rate count, set wins
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            intFlag <= 1'b0;
        end else if (opWrap) begin
            intFlag <= 1'b1;
        end else if (wr && paddr == OFS_STATUS && pwdata[0]) begin
            intFlag <= 1'b0;
        end
    end

    // DMA pointer steps at rate count
    always_ff @(posedge core_clk) begin
        if (!rstn || !ctrlOne[B_ON]) begin
            dmaPtr <= 8'h0;
        end else if (opWrap) begin
            dmaPtr <= (dmaPtr + 8'h1 >= bufCfg[B_BUF_SIZE +: 8]) ? 8'h0 : dmaPtr + 8'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            dmaReq <= 1'b0;
            dmaAddr <= 12'h0;
            dmaData <= 16'h0;
        end else begin
            dmaReq <= opWrap && bufCfg[B_DMA_ATT];
            if (opWrap) begin
                dmaData <= result;
                dmaAddr <= ctrlOne[B_BUILD_ORDER] ? {8'h00, wrPtr}
                         : 12'(convReq.chan * bufCfg[B_BUF_SIZE +: 8]) + {4'h0, dmaPtr};
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            digitalIn <= 9'h0;
            refSel <= 3'h0;
        end else begin
            digitalIn <= padIn & pinCfg[8:0] & otherPinCfg;
            refSel <= ctrlTwo[B_REF +: 3];
        end
    end

    // Conversion clock divider
    always_ff @(posedge core_clk) begin
        if (!rstn || !ctrlOne[B_ON]) begin
            divCnt <= 8'h0;
            convClk <= 1'b0;
        end else if (divCnt >= ctrlThree[7:0]) begin
            divCnt <= 8'h0;
            convClk <= !convClk;
        end else begin
            divCnt <= divCnt + 8'h1;
        end
    end

    chk_done_clear: assert property (@(posedge core_clk) disable iff (!rstn)
        hwStart |=> !ctrlOne[B_DONE]) else $error("done not cleared");
    chk_done_held: assert property (@(posedge core_clk) disable iff (!rstn)
        (ctrlOne[B_DONE] && !hwStart && !(wr && paddr == OFS_CTRL_ONE && !pwdata[B_DONE])) |=> ctrlOne[B_DONE])
        else $error("done not held");
    chk_single_slot: assert property (@(posedge core_clk) disable iff (!rstn)
        (convReq.start && convReq.res12) |-> convReq.slot == 2'h0 && sampleHold[3:1] == 3'h0) else
        $error("extra slot in 12-bit");
    chk_mode_frozen: assert property (@(posedge core_clk) disable iff (!rstn)
        $past(ctrlOne[B_ON]) |-> ctrlOne[B_MODE] == $past(ctrlOne[B_MODE])) else $error("mode changed while on");
    chk_flag_rate: assert property (@(posedge core_clk) disable iff (!rstn)
        opDone |=> (intFlag == ($past(opCount) >= $past(ctrlTwo[5:2])) || $past(intFlag))) else
        $error("flag rate wrong");
    chk_dma_request: assert property (@(posedge core_clk) disable iff (!rstn)
        (opWrap && bufCfg[B_DMA_ATT]) |=> dmaReq && intFlag ##1 !dmaReq) else $error("dma request missing");
    chk_counter_off: assert property (@(posedge core_clk) disable iff (!rstn)
        !ctrlOne[B_ON] |=> opCount == 4'h0 && wrPtr == 4'h0) else $error("counter kept while off");
    chk_pointer_wrap: assert property (@(posedge core_clk) disable iff (!rstn)
        (opWrap && ctrlOne[B_ON]) |=> wrPtr == 4'h0) else $error("pointer did not wrap");
    chk_auto_restart: assert property (@(posedge core_clk) disable iff (!rstn)
        (opDone && ctrlOne[B_AUTO] && ctrlOne[B_ON]) |=> state == ST_SAMPLE ##1 sampleHold[0]) else
        $error("no auto restart");
    chk_digital_gate: assert property (@(posedge core_clk) disable iff (!rstn)
        !otherPinCfg[0] ##1 1'b1 |-> !digitalIn[0]) else $error("digital input not gated");
endmodule : adc_seq_ctrl

// >>> adc_analog_model.sv
// Behavioural analog core answering conversion requests
`timescale 1ns/100ps
module adc_analog_model
    import adc_ctrl_pkg::*;
#(
    parameter int DLY = 6
)
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire convReq_t convReq,
    output logic convDone,
    output logic [11:0] convData
);
    int cnt;
    logic [11:0] code;
    // Data line toggles to its own inverse every cycle outside reset and the done pulse
    always_ff @(posedge core_clk) begin
        convDone <= 1'b0;
        convData <= ~convData;
        if (!rstn) begin
            cnt <= 0;
            convData <= 12'h000;
            code <= 12'h000;
        end else if (convReq.start) begin
            cnt <= DLY;
            code <= {convReq.chan, 8'h3c};
        end else if (cnt == 1) begin
            cnt <= 0;
            convDone <= 1'b1;
            convData <= code;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule : adc_analog_model

// >>> adc_seq_ctrl_test.sv
// Self-checking bench for the converter sequencing block
`timescale 1ns/100ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; $display("mismatch %s exp %h got %h", n, e, g); end end
module adc_seq_ctrl_test;
    import adc_ctrl_pkg::*;
    logic core_clk, rstn, psel, penable, pwrite, pready, pslverr, convDone, convClk, dmaReq, intFlag;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [11:0] convData, dmaAddr, dmaA;
    logic [15:0] dmaData, dmaD;
    logic [8:0] padIn, otherPinCfg, digitalIn;
    logic [3:0] sampleHold;
    logic [2:0] refSel;
    logic err;
    convReq_t convReq, lastReq;
    int fails = 0, num_checks = 0, startCnt = 0, dmaCnt = 0, cyc = 0, s;
    adc_seq_ctrl adc_seq_ctrl_inst (.core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .convDone(convDone), .convData(convData), .trigEvent(8'h00), .padIn(padIn), .otherPinCfg(otherPinCfg),
        .convReq(convReq), .sampleHold(sampleHold), .convClk(convClk), .refSel(refSel), .dmaReq(dmaReq),
        .dmaAddr(dmaAddr), .dmaData(dmaData), .intFlag(intFlag), .digitalIn(digitalIn));
    adc_analog_model adc_analog_model_inst (.core_clk(core_clk), .rstn(rstn), .convReq(convReq),
        .convDone(convDone), .convData(convData));
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (convReq.start === 1'b1) begin
            startCnt++;
            lastReq <= convReq;
        end
        if (dmaReq === 1'b1) begin
            dmaCnt++;
            dmaA <= dmaAddr;
            dmaD <= dmaData;
        end
        if (cyc == 20000) begin
            fails++;
            summarize();
        end
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge core_clk);
        end
        if (n == 20) fails++;
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    // Manual sample then software trigger, waits for done
    task automatic conv(input logic [31:0] c);
        int n;
        n = 0;
        wr(OFS_CTRL_ONE, c | 32'h2);
        wr(OFS_CTRL_ONE, c);
        q = 32'h0;
        while (q[0] !== 1'b1 && n < 30) begin
            n++;
            apb(1'b0, OFS_CTRL_ONE, 32'h0);
        end
        if (n == 30) fails++;
        repeat (40) @(posedge core_clk);
    endtask : conv
    task automatic t_regs;
        apb(1'b0, OFS_CTRL_ONE, 32'h0);
        `CHK("ctrl one reset", 32'h0, q)
        apb(1'b0, OFS_BUF_CFG, 32'h0);
        `CHK("buf cfg reset", 32'h00001000, q)
        apb(1'b0, 8'h30, 32'h0);
        `CHK("unmapped err", 1'b1, err)
        wr(OFS_CTRL_ONE, 32'h8000);
        wr(OFS_CTRL_ONE, 32'h8400);
        apb(1'b0, OFS_CTRL_ONE, 32'h0);
        `CHK("mode locked while on", 32'h8000, q)
        wr(OFS_CTRL_ONE, 32'h0);
        $display("test regs done");
    endtask : t_regs
    task automatic t_single;
        wr(OFS_CTRL_ONE, 32'h0400);
        wr(OFS_BUF_CFG, 32'h1050);
        wr(OFS_CTRL_ONE, 32'h8400);
        s = startCnt;
        wr(OFS_CTRL_ONE, 32'h8402);
        wr(OFS_CTRL_ONE, 32'h8400);
        apb(1'b0, OFS_CTRL_ONE, 32'h0);
        `CHK("done clear at start", 1'b0, q[0])
        conv(32'h8400);
        `CHK("one slot in 12-bit", 1, startCnt - s - 1)
        `CHK("req res12 chan", 5'h15, {lastReq.res12, lastReq.chan})
        apb(1'b0, OFS_CTRL_ONE, 32'h0);
        `CHK("done holds", 1'b1, q[0])
        apb(1'b0, 8'h40, 32'h0);
        `CHK("result 12-bit", 32'h053c, q)
        `CHK("flag every op", 1'b1, intFlag)
        wr(OFS_STATUS, 32'h1);
        @(posedge core_clk);
        `CHK("flag cleared", 1'b0, intFlag)
        $display("test single done");
    endtask : t_single
    task automatic t_four;
        wr(OFS_CTRL_ONE, 32'h0);
        wr(OFS_BUF_CFG, 32'h1000);
        wr(OFS_CTRL_TWO, 32'h0200);
        wr(OFS_CTRL_ONE, 32'h8000);
        wr(OFS_CTRL_ONE, 32'h8002);
        repeat (3) @(posedge core_clk);
        `CHK("four S&H sampling", 4'hf, sampleHold)
        s = startCnt;
        conv(32'h8000);
        `CHK("four slots", 4, startCnt - s)
        for (int k = 0; k < 4; k++) begin
            apb(1'b0, 8'(8'h40 + 4 * k), 32'h0);
            `CHK("result 10-bit", {22'h0, 2'(k), 8'h3c}, q)
        end
        wr(OFS_STATUS, 32'h1);
        $display("test four done");
    endtask : t_four
    task automatic t_dma;
        wr(OFS_CTRL_ONE, 32'h0);
        wr(OFS_CTRL_TWO, 32'h0004);
        wr(OFS_BUF_CFG, 32'h1051);
        wr(OFS_CTRL_ONE, 32'h0400);
        s = dmaCnt;
        conv(32'h8400);
        `CHK("no dma first op", 0, dmaCnt - s)
        `CHK("no flag first op", 1'b0, intFlag)
        conv(32'h8400);
        `CHK("dma on second op", 1, dmaCnt - s)
        `CHK("dma data", 16'h053c, dmaD)
        `CHK("scatter addr", 8'h05, dmaA[11:4])
        apb(1'b0, 8'h40, 32'h0);
        `CHK("single result reg", 32'h053c, q)
        wr(OFS_CTRL_ONE, 32'h0);
        apb(1'b0, OFS_STATUS, 32'h0);
        `CHK("counter off zero", 4'h0, q[19:16])
        wr(OFS_STATUS, 32'h1);
        $display("test dma done");
    endtask : t_dma
    task automatic t_trig;
        wr(OFS_CTRL_TWO, 32'h0);
        wr(OFS_BUF_CFG, 32'h1000);
        wr(OFS_CTRL_THREE, 32'h0200);
        wr(OFS_CTRL_ONE, 32'h04c0);
        s = startCnt;
        wr(OFS_CTRL_ONE, 32'h84c2);
        repeat (30) @(posedge core_clk);
        `CHK("reserved trigger", 0, startCnt - s)
        wr(OFS_CTRL_ONE, 32'h04e4);
        wr(OFS_CTRL_ONE, 32'h84e6);
        repeat (100) @(posedge core_clk);
        `CHK("auto restarts", 1'b1, startCnt - s >= 3)
        wr(OFS_CTRL_ONE, 32'h0);
        wr(OFS_PIN_CFG_LOW, 32'h00f5);
        repeat (3) @(posedge core_clk);
        `CHK("digital and", 9'h034, digitalIn)
        $display("test trig done");
    endtask : t_trig
    task automatic summarize;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize
    initial begin
        rstn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        padIn = 9'h1ff;
        otherPinCfg = 9'h13c;
        repeat (20) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        t_regs();
        t_single();
        t_four();
        t_dma();
        t_trig();
        summarize();
    end
endmodule : adc_seq_ctrl_test
